// ### hdl/ulpi_command_status_layer.sv
// transceiver side command decode and status byte sender
`timescale 1ns/1ps
module ulpi_command_status_layer
  import ulpi_cmd_pkg::*;
#(
  parameter longint ID_SETTLE_CYCLES = ID_SETTLE_CYC
) (
  input  wire logic                           CLK_IN,
  input  wire logic                           RST_IN,
  input  wire logic [ulpi_cmd_pkg::DATA_W-1:0] DATA_IN,
  output logic      [ulpi_cmd_pkg::DATA_W-1:0] DATA_OUT,
  output logic      [ulpi_cmd_pkg::DATA_W-1:0] DATA_OE_N_OUT,
  output logic                                DIR_OUT,
  output logic                                NXT_OUT,
  input  wire logic                           DP_IN,
  input  wire logic                           DM_IN,
  input  wire logic                           SQUELCH_IN,
  input  wire logic                           HS_DIFF_IN,
  input  wire logic                           ID_IN,
  input  wire logic                           SESS_END_IN,
  input  wire logic                           SESS_VLD_IN,
  input  wire logic                           VBUS_VLD_IN,
  input  wire logic                           BVALID_IN,
  input  wire logic                           RX_ACTIVE_IN,
  input  wire logic                           RX_ERROR_IN,
  input  wire logic                           HOST_DISCON_IN,
  input  wire logic [1:0]                     XCVR_SELECT_IN,
  input  wire logic                           TERM_SELECT_IN,
  input  wire logic                           ID_PULLUP_IN,
  input  wire logic                           VBUS_RISE_EN_IN,
  input  wire logic                           VBUS_FALL_EN_IN,
  input  wire logic                           BVALID_RISE_EN_IN,
  input  wire logic                           BVALID_FALL_EN_IN,
  input  wire logic                           TX_DONE_IN,
  output logic                                IDLE_CMD_OUT,
  output logic                                TX_START_OUT,
  output logic                                TX_PIDLESS_OUT,
  output logic [3:0]                          TX_PID_OUT,
  output logic                                REG_WRITE_OUT,
  output logic                                REG_READ_OUT,
  output logic [7:0]                          REG_ADDR_OUT,
  output logic                                USB_DRIVE_OUT,
  output logic                                ILLEGAL_CMD_OUT,
  output logic                                ID_VALID_OUT
);
  import ulpi_cmd_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXT_ADDR,
    ST_PIDLESS_DATA,
    ST_TX_BUSY,
    ST_STATUS
  } state_e;

  localparam int SYNC_W = 16;
  localparam logic [31:0] ID_LIMIT = 32'(ID_SETTLE_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic [7:0]        data_s;

  // front-end levels are asynchronous to the link clock
  assign pins_raw = {DP_IN,
                     DM_IN,
                     SQUELCH_IN,
                     HS_DIFF_IN,
                     ID_IN,
                     SESS_END_IN,
                     SESS_VLD_IN,
                     VBUS_VLD_IN,
                     BVALID_IN,
                     RX_ACTIVE_IN,
                     RX_ERROR_IN,
                     HOST_DISCON_IN,
                     4'h0};

  ulpi_sync2 #(.W(SYNC_W)) u_pin_sync (
    .clk_in (CLK_IN),
    .rst_in (RST_IN),
    .d_in   (pins_raw),
    .q_out  (pins_s)
  );

  // link data is on the same interface clock, no synchroniser needed
  assign data_s = DATA_IN;

  logic dp_s;
  logic dm_s;
  logic sq_s;
  logic hsd_s;
  logic id_s;
  logic send_s;
  logic svld_s;
  logic vvld_s;
  logic bvld_s;
  logic rxa_s;
  logic rxe_s;
  logic disc_s;
  assign {dp_s, dm_s, sq_s, hsd_s, id_s, send_s, svld_s, vvld_s, bvld_s,
          rxa_s, rxe_s, disc_s} = pins_s[SYNC_W-1:4];

  ////////////////////////////////////////////////////////////////////////////
  // status field encoding
  logic [1:0] line_enc;
  logic [1:0] vbus_enc;
  logic [1:0] event_enc;
  logic       hs_mode;
  logic       chirp_mode;

  assign hs_mode    = (XCVR_SELECT_IN == XCVR_HS) && !TERM_SELECT_IN;
  assign chirp_mode = (XCVR_SELECT_IN == XCVR_HS) && TERM_SELECT_IN;

  // full speed passes raw lines; hs reports squelch state, chirp reports squelch then hs differential
  assign line_enc = hs_mode    ? {1'b0, !sq_s} :
                    chirp_mode ? (sq_s ? 2'h0 : (hsd_s ? 2'h1 : 2'h2)) :
                                 {dm_s, dp_s};

  assign vbus_enc = vvld_s ? VBUS_VBUS_VLD :
                    svld_s ? VBUS_SESS_VLD :
                    send_s ? VBUS_BELOW_END : VBUS_END_TO_VLD;

  assign event_enc = disc_s ? EVENT_DISCON :
                     !rxa_s ? EVENT_NONE :
                     rxe_s  ? EVENT_ERROR : EVENT_ACTIVE;

  ////////////////////////////////////////////////////////////////////////////
  // id settle timer, id bit valid once the pull-up has been on long enough
  // limitation: id edges before the settle time are held back, reported once it has passed if the level still differs
  logic [31:0] id_cnt_q;
  logic        id_ok;
  assign id_ok = (id_cnt_q >= ID_LIMIT);

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) id_cnt_q <= 32'h0;
    else if (!ID_PULLUP_IN) id_cnt_q <= 32'h0;
    else if (!id_ok) id_cnt_q <= id_cnt_q + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // change detection
  logic [1:0] line_q;
  logic [1:0] vbus_q;
  logic [1:0] event_q;
  logic       id_q;
  logic       bvld_q;
  logic       line_chg;
  logic       vbus_rise;
  logic       vbus_fall;
  logic       vbus_chg;
  logic       event_chg;
  logic       id_chg;
  logic       alt_evt;
  logic       status_evt;
  logic       pend_q;
  logic       alt_pend_q;
  logic [1:0] vbus_next;
  logic       id_next;
  logic       alt_next;
  logic [7:0] status_byte;

  assign line_chg  = (line_enc != line_q);
  assign vbus_rise = (vbus_enc > vbus_q);
  assign vbus_fall = (vbus_enc < vbus_q);
  assign vbus_chg  = (vbus_rise && VBUS_RISE_EN_IN) ||
                     (vbus_fall && VBUS_FALL_EN_IN);
  assign event_chg = (event_enc != event_q);
  assign id_chg    = id_ok && (id_s != id_q);
  assign alt_evt   = (bvld_s && !bvld_q && BVALID_RISE_EN_IN) ||
                     (!bvld_s && bvld_q && BVALID_FALL_EN_IN);
  assign status_evt = line_chg || vbus_chg || event_chg || id_chg || alt_evt;

  // byte carries this cycle's values, so the triggering change is in it
  assign vbus_next   = vbus_chg ? vbus_enc : vbus_q;
  assign id_next     = id_ok ? id_s : id_q;
  assign alt_next    = alt_evt || alt_pend_q;
  assign status_byte = {alt_next, id_next, event_enc, vbus_next, line_enc};

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  logic [1:0] cmd_type;
  logic [5:0] cmd_pay;
  logic       is_idle;
  logic       is_pidless;
  logic       is_pid;
  logic       is_ext_w;
  logic       is_imm_w;
  logic       is_ext_r;
  logic       is_imm_r;
  logic       cmd_legal;

  assign cmd_type   = data_s[TYPE_MSB:TYPE_LSB];
  assign cmd_pay    = data_s[5:0];
  assign is_idle    = (cmd_type == TYPE_IDLE) && (cmd_pay == PAYLOAD_ZERO);
  assign is_pidless = (cmd_type == TYPE_TRANSMIT) && (cmd_pay == PAYLOAD_ZERO);
  assign is_pid     = (cmd_type == TYPE_TRANSMIT) && (cmd_pay[5:4] == 2'h0)
                      && (cmd_pay[3:0] != 4'h0);
  assign is_ext_w   = (cmd_type == TYPE_WRITE) && (cmd_pay == PAYLOAD_EXT);
  assign is_imm_w   = (cmd_type == TYPE_WRITE) && (cmd_pay != PAYLOAD_EXT);
  assign is_ext_r   = (cmd_type == TYPE_READ) && (cmd_pay == PAYLOAD_EXT);
  assign is_imm_r   = (cmd_type == TYPE_READ) && (cmd_pay != PAYLOAD_EXT);
  assign cmd_legal  = is_pidless || is_pid || is_ext_w || is_imm_w ||
                      is_ext_r || is_imm_r;

  ////////////////////////////////////////////////////////////////////////////
  // main sequencer
  state_e state_q, state_d;
  logic   ext_read_q;
  logic   start_status;

  // status only while the bus is ours to turn: idle with link quiet
  // (idle byte on the bus); commands win when both arrive together
  assign start_status = (pend_q || status_evt) && (state_q == ST_IDLE)
                        && is_idle;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (is_ext_w || is_ext_r) state_d = ST_EXT_ADDR;
        else if (is_pidless) state_d = ST_PIDLESS_DATA;
        else if (is_pid) state_d = ST_TX_BUSY;
        else if (start_status) state_d = ST_STATUS;
      end
      ST_EXT_ADDR:     state_d = ST_IDLE;
      ST_PIDLESS_DATA: state_d = ST_TX_BUSY;
      ST_TX_BUSY:      if (TX_DONE_IN) state_d = ST_IDLE;
      ST_STATUS:       state_d = ST_IDLE;
      default:         state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_q    <= ST_IDLE;
      ext_read_q <= 1'b0;
      line_q     <= 2'h0;
      vbus_q     <= VBUS_BELOW_END;
      event_q    <= EVENT_NONE;
      id_q       <= 1'b0;
      bvld_q     <= 1'b0;
      pend_q     <= 1'b0;
      alt_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE) ext_read_q <= is_ext_r;
      line_q  <= line_enc;
      if (vbus_chg) vbus_q <= vbus_enc;
      event_q <= event_enc;
      if (id_ok) id_q <= id_s;
      bvld_q  <= bvld_s;
      // an event in the send cycle rides in that byte, else it stays pending
      pend_q     <= (status_evt || pend_q) && !start_status;
      alt_pend_q <= alt_next && !start_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  logic in_idle;
  logic send_now;
  logic take_addr;
  logic accept;

  assign in_idle   = (state_q == ST_IDLE);
  assign send_now  = (state_d == ST_STATUS);
  assign take_addr = (state_q == ST_EXT_ADDR);
  assign accept    = in_idle && cmd_legal;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      DATA_OUT        <= DATA_RESET;
      DATA_OE_N_OUT   <= 8'hFF;
      DIR_OUT         <= 1'b0;
      NXT_OUT         <= 1'b0;
      IDLE_CMD_OUT    <= 1'b1;
      TX_START_OUT    <= 1'b0;
      TX_PIDLESS_OUT  <= 1'b0;
      TX_PID_OUT      <= 4'h0;
      REG_WRITE_OUT   <= 1'b0;
      REG_READ_OUT    <= 1'b0;
      REG_ADDR_OUT    <= 8'h00;
      USB_DRIVE_OUT   <= 1'b0;
      ILLEGAL_CMD_OUT <= 1'b0;
      ID_VALID_OUT    <= 1'b0;
    end else begin
      NXT_OUT         <= accept || (state_q == ST_PIDLESS_DATA)
                         || take_addr;
      DIR_OUT         <= send_now;
      DATA_OUT        <= send_now ? status_byte : DATA_RESET;
      DATA_OE_N_OUT   <= send_now ? 8'h00 : 8'hFF;
      IDLE_CMD_OUT    <= in_idle && is_idle;
      TX_START_OUT    <= (state_q == ST_IDLE) && (is_pid || is_pidless);
      TX_PIDLESS_OUT  <= (state_q == ST_IDLE) && is_pidless;
      if ((state_q == ST_IDLE) && is_pid) TX_PID_OUT <= data_s[3:0];
      REG_WRITE_OUT   <= ((state_q == ST_IDLE) && is_imm_w) ||
                         ((state_q == ST_EXT_ADDR) && !ext_read_q);
      REG_READ_OUT    <= ((state_q == ST_IDLE) && is_imm_r) ||
                         ((state_q == ST_EXT_ADDR) && ext_read_q);
      if ((state_q == ST_IDLE) && (is_imm_w || is_imm_r))
        REG_ADDR_OUT  <= {2'h0, cmd_pay};
      else if (state_q == ST_EXT_ADDR)
        REG_ADDR_OUT  <= data_s;
      USB_DRIVE_OUT   <= (state_d == ST_TX_BUSY);
      ILLEGAL_CMD_OUT <= (state_q == ST_IDLE) && !is_idle && !cmd_legal;
      ID_VALID_OUT    <= id_ok;
    end
  end
endmodule

// ### hdl/ulpi_cmd_pkg.sv
// shared constants for the link command and status layer
package ulpi_cmd_pkg;
  localparam int          DATA_W          = 8;
  localparam logic [1:0]  TYPE_IDLE       = 2'h0;
  localparam logic [1:0]  TYPE_TRANSMIT   = 2'h1;
  localparam logic [1:0]  TYPE_WRITE      = 2'h2;
  localparam logic [1:0]  TYPE_READ       = 2'h3;
  localparam logic [5:0]  PAYLOAD_ZERO    = 6'h00;
  localparam logic [5:0]  PAYLOAD_EXT     = 6'h2F;
  localparam int          TYPE_MSB        = 7;
  localparam int          TYPE_LSB        = 6;
  localparam int          LINE_LSB        = 0;
  localparam int          VBUS_LSB        = 2;
  localparam int          EVENT_LSB       = 4;
  localparam int          ID_BIT          = 6;
  localparam int          ALT_BIT         = 7;
  localparam logic [1:0]  VBUS_BELOW_END  = 2'h0;
  localparam logic [1:0]  VBUS_END_TO_VLD = 2'h1;
  localparam logic [1:0]  VBUS_SESS_VLD   = 2'h2;
  localparam logic [1:0]  VBUS_VBUS_VLD   = 2'h3;
  localparam logic [1:0]  EVENT_NONE      = 2'h0;
  localparam logic [1:0]  EVENT_ACTIVE    = 2'h1;
  localparam logic [1:0]  EVENT_ERROR     = 2'h3;
  localparam logic [1:0]  EVENT_DISCON    = 2'h2;
  localparam logic [1:0]  XCVR_HS         = 2'h0;
  localparam logic [7:0]  DATA_RESET      = 8'h00;
  localparam longint      CLK_HZ          = 125000000;
  localparam longint      ID_SETTLE_MS    = 50;
  localparam longint      ID_SETTLE_CYC   = (ID_SETTLE_MS * CLK_HZ) / 1000;
endpackage

// ### hdl/ulpi_sync2.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module ulpi_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule

// ### verification/ulpi_link_model.sv
// link controller model that streams command bytes and collects status
`timescale 1ns/1ps
module ulpi_link_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       dir_in,
  input  wire logic [7:0] bus_in,
  output logic      [7:0] data_out,
  output logic            drive_out,
  output logic      [7:0] rx_byte_out,
  output int              rx_count_out
);
  logic [7:0] q [$];
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // release at once, the transceiver owns the bus while dir is up
  assign drive_out = !dir_in;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_out     <= 8'h00;
      rx_byte_out  <= 8'h00;
      rx_count_out <= 0;
    end else if (dir_in) begin
      rx_byte_out  <= bus_in;
      rx_count_out <= rx_count_out + 1;
    end else if (q.size() > 0) begin
      data_out <= q.pop_front();
    end else begin
      data_out <= 8'h00;
    end
  end
endmodule

// ### verification/ulpi_command_status_layer_asserts.sv
// concurrent checks on the command decode and status ports
`timescale 1ns/1ps
module ulpi_cmd_status_asserts #(
  parameter longint ID_SETTLE_CYCLES = 20
) (
  input wire logic       CLK_IN,
  input wire logic       RST_IN,
  input wire logic [7:0] DATA_IN,
  input wire logic [7:0] DATA_OUT,
  input wire logic [7:0] DATA_OE_N_OUT,
  input wire logic       DIR_OUT,
  input wire logic       NXT_OUT,
  input wire logic       DP_IN,
  input wire logic       DM_IN,
  input wire logic       RX_ACTIVE_IN,
  input wire logic       RX_ERROR_IN,
  input wire logic       HOST_DISCON_IN,
  input wire logic [1:0] XCVR_SELECT_IN,
  input wire logic       TERM_SELECT_IN,
  input wire logic       ID_PULLUP_IN,
  input wire logic       TX_START_OUT,
  input wire logic       TX_PIDLESS_OUT,
  input wire logic [3:0] TX_PID_OUT,
  input wire logic       REG_WRITE_OUT,
  input wire logic       REG_READ_OUT,
  input wire logic [7:0] REG_ADDR_OUT,
  input wire logic       USB_DRIVE_OUT,
  input wire logic       ID_VALID_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic [1:0] evt_code;
  logic       fs_mode;
  longint     pull_q;
  assign evt_code = HOST_DISCON_IN ? 2'h2 : {RX_ACTIVE_IN & RX_ERROR_IN, RX_ACTIVE_IN};
  assign fs_mode  = XCVR_SELECT_IN[0] & TERM_SELECT_IN;
  // saturates so a long pull-up never wraps
  always_ff @(posedge CLK_IN or posedge RST_IN)
    if (RST_IN) pull_q <= 0;
    else pull_q <= ID_PULLUP_IN ? pull_q + (pull_q < ID_SETTLE_CYCLES + 8) : 0;
  ////////////////////////////////////////
  imm_read_a: assert property (
    REG_READ_OUT && $past(DATA_IN, 2) != 8'hEF |->
    NXT_OUT && REG_ADDR_OUT == {2'h0, $past(DATA_IN[5:0])}) else $error("read address wrong");
  ext_write_a: assert property (
    REG_WRITE_OUT && $past(DATA_IN, 2) == 8'hAF |->
    $past(NXT_OUT) && REG_ADDR_OUT == $past(DATA_IN)) else $error("extended address wrong");
  tx_pid_a: assert property (
    TX_START_OUT && !TX_PIDLESS_OUT |-> NXT_OUT && USB_DRIVE_OUT &&
    TX_PID_OUT == $past(DATA_IN[3:0])) else $error("packet id wrong");
  pidless_wait_a: assert property (
    TX_PIDLESS_OUT |-> TX_START_OUT && !USB_DRIVE_OUT ##1 NXT_OUT && USB_DRIVE_OUT)
    else $error("pidless transmit drove early");
  bus_turn_a: assert property (
    DATA_OE_N_OUT == (DIR_OUT ? 8'h00 : 8'hFF) && (DIR_OUT || DATA_OUT == 8'h00))
    else $error("data enables disagree with direction");
  line_report_a: assert property (
    $changed({DM_IN, DP_IN}) && fs_mode && DATA_IN == 8'h00 |-> ##[1:12] DIR_OUT)
    else $error("no status after line change");
  line_value_a: assert property (
    (fs_mode && $stable({DM_IN, DP_IN}))[*3] ##0 DIR_OUT |-> DATA_OUT[1:0] == {DM_IN, DP_IN})
    else $error("line state field wrong");
  rx_event_a: assert property (
    $stable({RX_ACTIVE_IN, RX_ERROR_IN, HOST_DISCON_IN})[*3] ##0 DIR_OUT |->
    DATA_OUT[5:4] == evt_code) else $error("receive event field wrong");
  id_early_a: assert property (
    ID_VALID_OUT |-> pull_q >= ID_SETTLE_CYCLES) else $error("id valid too early");
  id_late_a: assert property (
    pull_q >= ID_SETTLE_CYCLES + 6 |-> ID_VALID_OUT) else $error("id valid too late");
endmodule
bind ulpi_command_status_layer ulpi_cmd_status_asserts #(
  .ID_SETTLE_CYCLES(ID_SETTLE_CYCLES)
) ulpi_cmd_status_asserts_i (.*);

// ### verification/test_ulpi_command_status_layer.sv
// self-checking bench for the command decode and status layer
`timescale 1ns/1ps
module test_ulpi_command_status_layer;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic [11:0] fe   = 12'h000;  // dm dp sq diff se sv vv act err dis id bvalid
  logic [1:0]  xc   = 2'h1;
  logic        tm   = 1'b1;
  logic [3:0]  en   = 4'hF;     // vbus rise, vbus fall, bvalid rise, bvalid fall
  logic        pull = 1'b0;
  logic        done = 1'b0;
  wire  [7:0]  bus, dout, oe_n, lk_d, rx_b, addr;
  wire  [3:0]  pid;
  wire         dir, nxt, lk_drv, ill, pl, txs, wr, rd, idle, idv, drv;
  wire  [5:0]  mon = {nxt, ill, pl, txs, rd, wr};
  int          rx_n, err_count, total_checks, cyc;
  int          cnt [6] = '{default: 0};
  int          snap [6];
  // cmd, follow byte, counts {nxt ill pidless start read write}, address or pid
  logic [35:0] rows [13] = '{
    {8'h00, 8'h00, 12'b00_00_00_00_00_00, 8'h00}, {8'h85, 8'h00, 12'b01_00_00_00_00_01, 8'h05},
    {8'hBF, 8'h00, 12'b01_00_00_00_00_01, 8'h3F}, {8'hAF, 8'hA5, 12'b10_00_00_00_00_01, 8'hA5},
    {8'hC0, 8'h00, 12'b01_00_00_00_01_00, 8'h00}, {8'hFF, 8'h00, 12'b01_00_00_00_01_00, 8'h3F},
    {8'hEF, 8'h3C, 12'b10_00_00_00_01_00, 8'h3C}, {8'h41, 8'h85, 12'b01_00_00_01_00_00, 8'h01},
    {8'h4F, 8'h00, 12'b01_00_00_01_00_00, 8'h0F}, {8'h40, 8'h5A, 12'b10_00_01_01_00_00, 8'h00},
    {8'h50, 8'h00, 12'b00_01_00_00_00_00, 8'h00}, {8'h01, 8'h00, 12'b00_01_00_00_00_00, 8'h00},
    {8'h85, 8'h86, 12'b10_00_00_00_00_10, 8'h06}};
  // mode, term, front-end levels, expected status bits 5:0
  logic [18:0] srows [12] = '{
    19'b01_1_0100100000_000001, 19'b01_1_1000000000_000110, 19'b01_1_1100010000_001011,
    19'b01_1_0000011000_001100, 19'b01_1_0000011100_011100, 19'b01_1_0000011110_111100,
    19'b01_1_0000011001_101100, 19'b00_1_0010011000_001100, 19'b00_1_0001011000_001101,
    19'b00_1_0000011000_001110, 19'b00_0_0010011000_001100, 19'b00_0_0000011000_001101};
  always #4 clk = ~clk;
  // undriven wire shows the inverse of the last byte, never a held value
  assign bus = (~oe_n & dout) | (oe_n & (lk_drv ? lk_d : ~lk_d));
  ulpi_command_status_layer #(.ID_SETTLE_CYCLES(20)) ulpi_command_status_layer_i (
    .CLK_IN(clk), .RST_IN(rst), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE_N_OUT(oe_n),
    .DIR_OUT(dir), .NXT_OUT(nxt), .DM_IN(fe[11]), .DP_IN(fe[10]), .SQUELCH_IN(fe[9]),
    .HS_DIFF_IN(fe[8]), .SESS_END_IN(fe[7]), .SESS_VLD_IN(fe[6]), .VBUS_VLD_IN(fe[5]),
    .RX_ACTIVE_IN(fe[4]), .RX_ERROR_IN(fe[3]), .HOST_DISCON_IN(fe[2]), .ID_IN(fe[1]),
    .BVALID_IN(fe[0]), .XCVR_SELECT_IN(xc), .TERM_SELECT_IN(tm), .ID_PULLUP_IN(pull),
    .VBUS_RISE_EN_IN(en[3]), .VBUS_FALL_EN_IN(en[2]), .BVALID_RISE_EN_IN(en[1]),
    .BVALID_FALL_EN_IN(en[0]), .TX_DONE_IN(done), .IDLE_CMD_OUT(idle), .TX_START_OUT(txs),
    .TX_PIDLESS_OUT(pl), .TX_PID_OUT(pid), .REG_WRITE_OUT(wr), .REG_READ_OUT(rd),
    .REG_ADDR_OUT(addr), .USB_DRIVE_OUT(drv), .ILLEGAL_CMD_OUT(ill), .ID_VALID_OUT(idv));
  ulpi_link_model ulpi_link_model_i (
    .clk_in(clk), .rst_in(rst), .dir_in(dir), .bus_in(bus), .data_out(lk_d),
    .drive_out(lk_drv), .rx_byte_out(rx_b), .rx_count_out(rx_n));
  ////////////////////////////////////////
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (!rst) for (int k = 0; k < 6; k++) cnt[k] += int'(mon[k]);
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end
  ////////////////////////////////////////
  initial begin
    logic [35:0] r;
    logic [18:0] s;
    int          n;
    repeat (19) @(posedge clk);
    check8({idle, dir, nxt, 5'h0}, 8'h80, "reset flags");
    check8(oe_n & ~dout, 8'hFF, "reset bus");
    @(posedge clk) rst <= 1'b0;
    repeat (10) @(posedge clk);
    foreach (rows[i]) begin
      r = rows[i];
      @(negedge clk);
      snap = cnt;
      ulpi_link_model_i.push(r[35:28]);
      if (r[27:20] != 8'h00) ulpi_link_model_i.push(r[27:20]);
      repeat (8) @(negedge clk);
      for (int k = 0; k < 6; k++) check8(8'(cnt[k] - snap[k]), {6'h0, r[8+2*k +: 2]}, "count");
      if (|r[11:8]) check8(addr, r[7:0], "address");
      else if (|r[13:12] && !(|r[15:14])) check8({4'h0, pid}, r[7:0], "packet id");
      check8({7'h0, drv}, {7'h0, |r[13:12]}, "usb drive");
      if (|r[13:12]) begin
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
      end
    end
    foreach (srows[i]) begin
      s = srows[i];
      n = rx_n;
      @(posedge clk) {xc, tm, fe[11:2]} <= s[18:6];
      repeat (12) @(negedge clk);
      check8({7'h0, rx_n > n}, 8'h01, "status sent");
      check8({2'h0, rx_b[5:0]}, {2'h0, s[5:0]}, "status");
    end
    n = rx_n;
    @(posedge clk);
    en[3:2] <= 2'h0;
    fe[6:5] <= 2'h0;
    repeat (12) @(negedge clk);
    check8(8'(rx_n - n), 8'h00, "masked vbus");
    @(posedge clk) fe[0] <= 1'b1;
    repeat (12) @(negedge clk);
    check8({rx_b[7], 7'h0}, 8'h80, "alt bit");
    @(posedge clk);
    fe[1] <= 1'b1;
    pull  <= 1'b1;
    repeat (10) @(negedge clk);
    check8({7'h0, idv}, 8'h00, "id early");
    repeat (30) @(negedge clk);
    check8({6'h0, idv, rx_b[6]}, 8'h03, "id late");
    summarize();
  end
endmodule
